// File: src/idtr_pkg.sv
package idtr_pkg;

  // register word indices (printed offsets 0x00/0x01 kept as indices, address = 4 * index)
  localparam logic [7:0] IDTR_IDX_ID_LOW   = 8'h00;
  localparam logic [7:0] IDTR_IDX_ID_HIGH  = 8'h01;
  localparam logic [7:0] IDTR_IDX_REV      = 8'h02;
  localparam logic [7:0] IDTR_IDX_TEST     = 8'h03;
  localparam logic [7:0] IDTR_IDX_IRQ_STS  = 8'h04;
  localparam logic [7:0] IDTR_IDX_IRQ_MASK = 8'h05;

  // test control byte field positions
  localparam int IDTR_BIT_PHASE_LOST  = 7;
  localparam int IDTR_BIT_FORCE_FP    = 6;
  localparam int IDTR_BIT_RESYNC      = 4;
  localparam int IDTR_BIT_EDGE_POL    = 2;

  // reset values and the test byte write mask
  localparam logic [7:0] IDTR_TEST_RESET  = 8'h14;
  localparam logic [7:0] IDTR_WMASK_TEST  = 8'h54;
  localparam logic [1:0] IDTR_IRQ_RESET   = 2'h0;

  // power-up resync window
  localparam longint IDTR_RESYNC_WINDOW_S = 2;
  localparam longint IDTR_CLK_HZ          = 100_000_000;
  localparam longint IDTR_RESYNC_CYCLES   = IDTR_RESYNC_WINDOW_S * IDTR_CLK_HZ;

  // apb request carrier
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } idtr_apb_req_t;

  // outputs toward the main timing loop
  typedef struct packed {
    logic force_freq_phase;
    logic resync_dividers;
    logic rising_edge_lock;
  } idtr_loop_ctl_t;

endpackage : idtr_pkg

// File: src/idtr_regs.sv
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module idtr_regs
  import idtr_pkg::*;
#(
  parameter logic [15:0] DEVICE_ID     = 16'h5aa5,  // arbitrary value
  parameter logic [7:0]  SILICON_REV   = 8'h01,     // arbitrary value
  parameter longint      RESYNC_CYCLES = IDTR_RESYNC_CYCLES
)
(
  // clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  // apb slave
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [31:0]    paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  // main timing loop
  input  wire logic           phase_lost_pin,
  output idtr_pkg::idtr_loop_ctl_t loop_ctl,
  // interrupt
  output logic                irq
);
  import idtr_pkg::*;

  // apb request as one carrier, read by field name below
  idtr_apb_req_t  req;

  // access phase decode
  logic           acc;
  logic           wr;
  logic           rd_setup;
  logic           wr_test;
  logic           wr_sts;
  logic           wr_mask;

  // one select per register word
  logic           sel_low;
  logic           sel_high;
  logic           sel_rev;
  logic           sel_test;
  logic           sel_sts;
  logic           sel_mask;
  logic           mapped;

  // test control fields and the byte they form
  logic [7:0]     wdata_test;
  logic           ctl_force;
  logic           next_ctl_force;
  logic           ctl_resync;
  logic           next_ctl_resync;
  logic           ctl_edge;
  logic           next_ctl_edge;
  logic [7:0]     test_ctl;
  logic [7:0]     test_view;

  // interrupt status and mask, one flop per event
  logic           sts_lost;
  logic           next_sts_lost;
  logic           sts_regained;
  logic           next_sts_regained;
  logic           mask_lost;
  logic           next_mask_lost;
  logic           mask_regained;
  logic           next_mask_regained;
  logic [1:0]     irq_sts;
  logic [1:0]     irq_mask;
  logic [1:0]     sts_clr;
  logic [1:0]     ev;

  // power-up resync window
  logic [31:0]    win_cnt;
  logic [31:0]    next_win_cnt;
  logic           in_window;

  // lock status synchroniser and its edges
  logic           lost_meta;
  logic           lost_sync;
  logic           lost_prev;
  logic           lost_rise;
  logic           lost_fall;

  // read path and loop controls ahead of their flops
  logic [31:0]    rd_mux;
  logic [31:0]    next_prdata;
  idtr_loop_ctl_t next_loop_ctl;

  // word index decode; a misaligned byte address selects nothing
  function automatic logic hit(input logic [31:0] a, input logic [7:0] idx);
    hit = (a[1:0] == 2'b00) && (a[31:2] == {22'h0, idx});
  endfunction : hit

  // an 8-bit register sits in the low byte lane, upper lanes read zero
  function automatic logic [31:0] byte_lane(input logic [7:0] b);
    byte_lane = {24'h0, b};
  endfunction : byte_lane

  // carrier for the bus request
  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

  // setup loads read data, access commits writes
  assign acc      = req.sel && req.enable;
  assign wr       = acc && req.write;
  assign rd_setup = req.sel && !req.enable && !req.write;

  // address decode
  assign sel_low  = hit(req.addr, IDTR_IDX_ID_LOW);
  assign sel_high = hit(req.addr, IDTR_IDX_ID_HIGH);
  assign sel_rev  = hit(req.addr, IDTR_IDX_REV);
  assign sel_test = hit(req.addr, IDTR_IDX_TEST);
  assign sel_sts  = hit(req.addr, IDTR_IDX_IRQ_STS);
  assign sel_mask = hit(req.addr, IDTR_IDX_IRQ_MASK);
  assign mapped   = sel_low | sel_high | sel_rev | sel_test | sel_sts | sel_mask;

  // per-register write strobes; identity words have none, so writes there are lost
  assign wr_test  = wr && sel_test;
  assign wr_sts   = wr && sel_sts;
  assign wr_mask  = wr && sel_mask;

  // zero-wait slave; unmapped or misaligned addresses answer with an error
  assign pready   = 1'b1;
  assign pslverr  = acc && !mapped;

  // level interrupt with no flop, so it drops in the cycle after the clear
  assign irq      = |(irq_sts & irq_mask);

  // lock status comes from another block's pins, so two flops come before any logic
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lost_meta <= 1'b0;
    end
    else
    begin
      lost_meta <= phase_lost_pin;
    end
  end

  // second synchroniser stage; only this one is read by logic
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lost_sync <= 1'b0;
    end
    else
    begin
      lost_sync <= lost_meta;
    end
  end

  // previous level for the edge detector; resets to the locked level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lost_prev <= 1'b0;
    end
    else
    begin
      lost_prev <= lost_sync;
    end
  end

  // lock lost on a rise, lock regained on a fall
  assign lost_rise = lost_sync & ~lost_prev;
  assign lost_fall = ~lost_sync & lost_prev;
  assign ev        = {lost_fall, lost_rise};

  // only bits 6, 4 and 2 hold a value; test bits stay zero whatever is written
  assign wdata_test      = req.wdata[7:0] & IDTR_WMASK_TEST;
  assign next_ctl_force  = wr_test ? wdata_test[IDTR_BIT_FORCE_FP] : ctl_force;
  assign next_ctl_resync = wr_test ? wdata_test[IDTR_BIT_RESYNC] : ctl_resync;
  assign next_ctl_edge   = wr_test ? wdata_test[IDTR_BIT_EDGE_POL] : ctl_edge;

  // force combined frequency and phase locking
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_force <= IDTR_TEST_RESET[IDTR_BIT_FORCE_FP];
    end
    else
    begin
      ctl_force <= next_ctl_force;
    end
  end

  // keep the output dividers resynchronised
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_resync <= IDTR_TEST_RESET[IDTR_BIT_RESYNC];
    end
    else
    begin
      ctl_resync <= next_ctl_resync;
    end
  end

  // input edge used for locking
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_edge <= IDTR_TEST_RESET[IDTR_BIT_EDGE_POL];
    end
    else
    begin
      ctl_edge <= next_ctl_edge;
    end
  end

  // stored byte; unwritable positions are constant zero
  assign test_ctl = {1'b0, ctl_force, 1'b0, ctl_resync, 1'b0, ctl_edge, 2'b00};

  // a window longer than 2**32 cycles would be cut short by the cast
  assign in_window    = (win_cnt < 32'(RESYNC_CYCLES));
  assign next_win_cnt = in_window ? (win_cnt + 32'h0000_0001) : win_cnt;

  // window counter saturates, so the window never reopens without a reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      win_cnt <= 32'h0000_0000;
    end
    else
    begin
      win_cnt <= next_win_cnt;
    end
  end

  // write-one-to-clear; an event in the same cycle as its clear wins
  assign sts_clr            = wr_sts ? req.wdata[1:0] : 2'b00;
  assign next_sts_lost      = (sts_lost & ~sts_clr[0]) | ev[0];
  assign next_sts_regained  = (sts_regained & ~sts_clr[1]) | ev[1];
  assign next_mask_lost     = wr_mask ? req.wdata[0] : mask_lost;
  assign next_mask_regained = wr_mask ? req.wdata[1] : mask_regained;

  // status bit 0: lock lost
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sts_lost <= IDTR_IRQ_RESET[0];
    end
    else
    begin
      sts_lost <= next_sts_lost;
    end
  end

  // status bit 1: lock regained
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sts_regained <= IDTR_IRQ_RESET[1];
    end
    else
    begin
      sts_regained <= next_sts_regained;
    end
  end

  // mask bit 0, same layout as the status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_lost <= IDTR_IRQ_RESET[0];
    end
    else
    begin
      mask_lost <= next_mask_lost;
    end
  end

  // mask bit 1
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_regained <= IDTR_IRQ_RESET[1];
    end
    else
    begin
      mask_regained <= next_mask_regained;
    end
  end

  // status and mask as words
  assign irq_sts  = {sts_regained, sts_lost};
  assign irq_mask = {mask_regained, mask_lost};

  // bit 7 shows the synchronised lock flag live, bit 5 is unused and reads zero
  assign test_view = {lost_sync, test_ctl[6:0]};

  // read select
  assign rd_mux = sel_low  ? byte_lane(DEVICE_ID[7:0])  :
                  sel_high ? byte_lane(DEVICE_ID[15:8]) :
                  sel_rev  ? byte_lane(SILICON_REV)     :
                  sel_test ? byte_lane(test_view)       :
                  sel_sts  ? {30'h0, irq_sts}           :
                  sel_mask ? {30'h0, irq_mask}          :
                  32'h0000_0000;

  // read data is taken in the setup cycle, so it stands through the access cycle
  assign next_prdata = rd_setup ? rd_mux : prdata;

  // read data flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
    end
    else
    begin
      prdata <= next_prdata;
    end
  end

  // controls toward the main timing loop; a flop keeps them glitch free
  assign next_loop_ctl.force_freq_phase = ctl_force;
  assign next_loop_ctl.resync_dividers  = ctl_resync | in_window;
  assign next_loop_ctl.rising_edge_lock = ctl_edge;

  // loop control flops; they trail the test control register by one cycle, two after the write cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      loop_ctl <= '0;
    end
    else
    begin
      loop_ctl <= next_loop_ctl;
    end
  end

endmodule : idtr_regs

`default_nettype wire

// File: verif/idtr_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module idtr_regs_asserts
  import idtr_pkg::*;
#(parameter logic [15:0] DEVICE_ID = 16'h0, parameter logic [7:0] SILICON_REV = 8'h0)
(
  // apb, loop side and interrupt
  input wire logic        pclk, presetn, psel, penable, pwrite, pslverr, phase_lost_pin, irq,
  input wire logic [31:0] paddr, pwdata, prdata,
  input wire idtr_pkg::idtr_loop_ctl_t loop_ctl
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // read setup and committed test byte write
  wire rd = psel && !penable && !pwrite;
  wire wt = psel && penable && pwrite && paddr == 32'hc;
  property p_id; rd && (paddr == 32'h0 || paddr == 32'h4) |=>
    prdata == {24'h0, $past(paddr[2]) ? DEVICE_ID[15:8] : DEVICE_ID[7:0]}; endproperty
  property p_rev; rd && paddr == 32'h8 |=> prdata == {24'h0, SILICON_REV}; endproperty
  // the pin is synchronised, so only a settled level is compared
  property p_lost; $stable(phase_lost_pin) [*5] ##0 (rd && paddr == 32'hc) |=>
    prdata[7] == $past(phase_lost_pin); endproperty
  // the register and then the control flop each add one cycle
  property p_frc; wt |-> ##2 loop_ctl.force_freq_phase == $past(pwdata[6], 2); endproperty
  property p_rsy; wt && pwdata[4] |-> ##2 loop_ctl.resync_dividers; endproperty
  property p_rst; $rose(presetn) |=> loop_ctl == 3'b011; endproperty
  a_id: assert property (p_id) else $error("id byte");
  a_rev: assert property (p_rev) else $error("revision");
  a_lost: assert property (p_lost) else $error("lock flag");
  a_frc: assert property (p_frc) else $error("force lock");
  a_rsy: assert property (p_rsy) else $error("resync");
  a_rst: assert property (p_rst) else $error("reset ctl");
  // main scenarios
  c_wt: cover property (wt);
  c_irq: cover property (irq);
  c_err: cover property (pslverr);
endmodule : idtr_regs_asserts
bind idtr_regs idtr_regs_asserts #(.DEVICE_ID(DEVICE_ID), .SILICON_REV(SILICON_REV)) chk_u (.*);
`default_nettype wire

// File: verif/idtr_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module idtr_regs_tb;
  import idtr_pkg::*;
  // arbitrary values: revision, id high, id low
  localparam logic [23:0] RO = 24'h5b_c37e;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pin = 0, pready, pslverr, irq, err;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  idtr_loop_ctl_t loop_ctl;
  int          fails = 0, tests_run = 0, cyc = 0;
  idtr_regs #(.DEVICE_ID(RO[15:0]), .SILICON_REV(RO[23:16]), .RESYNC_CYCLES(20)) dut_u (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .phase_lost_pin(pin), .loop_ctl, .irq);
  initial forever #5 pclk = ~pclk;
  // a hung handshake ends the run; the sequence needs about 90 cycles
  always @(posedge pclk)
    if (++cyc == 1000)
    begin
      fails++;
      finish_test();
    end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    fails += int'(got !== exp);
    if (got !== exp) $display("[ERR] %0t got %h exp %h", $time, got, exp);
  endtask : cmp
  // request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic finish_test();
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 32'hc, 0);
    cmp(rd, 32'h14);
    // inside the power-up window resync stays high with bit 4 cleared
    apb(1, 32'hc, 32'h04);
    apb(0, 32'hc, 0);
    cmp({29'h0, loop_ctl}, 3);
    // read-only bytes must ignore an all-ones write
    for (int i = 0; i < 3; i++)
    begin
      apb(1, 4 * i, '1);
      apb(0, 4 * i, 0);
      cmp(rd, {24'h0, RO[8 * i +: 8]});
    end
    $display("identity done");
    pin <= 1'b1;
    repeat (25) @(posedge pclk);
    apb(1, 32'hc, 32'hf4);
    apb(0, 32'hc, 0);
    cmp(rd, 32'hd4);
    cmp({29'h0, loop_ctl}, 7);
    apb(1, 32'hc, 0);
    apb(0, 32'hc, 0);
    cmp(rd, 32'h80);
    cmp({29'h0, loop_ctl}, 0);
    $display("control done");
    // lock loss latched in status, raised once unmasked, then cleared
    apb(1, 32'h14, 1);
    apb(0, 32'h10, 0);
    cmp(rd, 1);
    cmp({31'h0, irq}, 1);
    apb(1, 32'h10, 1);
    apb(0, 32'h40, 0);
    cmp({30'h0, irq, err}, 1);
    $display("irq done");
    finish_test();
  end
endmodule : idtr_regs_tb
`default_nettype wire
